// file: src/cpu_regs_pkg.sv
package cpu_regs_pkg;

  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int WORD_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int LONG_W    = 32;
  localparam int ADR20_W   = 20;
  localparam int FLAG_W    = 11;
  localparam int IPL_W     = 3;
  localparam int BANK_N    = 2;
  localparam int BANK_REGS = 7;
  localparam int BANK_STEP = 8;
  localparam int SWI_W     = 6;
  localparam int BUS_AW    = 7;
  localparam int BUS_DW    = 32;
  localparam int BUS_BE_W  = 4;
  localparam int IDX_LSB   = 2;
  localparam int IDX_W     = 5;

  // ---------------------------------------------------------------
  // Flag word layout
  // ---------------------------------------------------------------
  localparam int FLG_C   = 0;
  localparam int FLG_D   = 1;
  localparam int FLG_Z   = 2;
  localparam int FLG_S   = 3;
  localparam int FLG_B   = 4;
  localparam int FLG_O   = 5;
  localparam int FLG_I   = 6;
  localparam int FLG_U   = 7;
  localparam int FLG_IPL = 8;
  localparam logic [FLAG_W-1:0] FLAG_RST = 11'h000;
  localparam logic [SWI_W-1:0]  SWI_CLR_MAX = 6'h1F;

  // Arithmetic flag update lanes.
  localparam int AF_C = 0;
  localparam int AF_Z = 1;
  localparam int AF_S = 2;
  localparam int AF_O = 3;
  localparam int AF_N = 4;

  // Banked entry positions.
  localparam int E_D0 = 0;
  localparam int E_D1 = 1;
  localparam int E_D2 = 2;
  localparam int E_D3 = 3;
  localparam int E_A0 = 4;
  localparam int E_A1 = 5;

  // ---------------------------------------------------------------
  // Bus word indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_SB  = 5'h10;
  localparam logic [IDX_W-1:0] IDX_VTB = 5'h11;
  localparam logic [IDX_W-1:0] IDX_PC  = 5'h12;
  localparam logic [IDX_W-1:0] IDX_USP = 5'h13;
  localparam logic [IDX_W-1:0] IDX_ISP = 5'h14;
  localparam logic [IDX_W-1:0] IDX_FLG = 5'h15;

  // ---------------------------------------------------------------
  // Register selectors and access sizes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SEL_D0  = 4'h0,
    SEL_D1  = 4'h1,
    SEL_D2  = 4'h2,
    SEL_D3  = 4'h3,
    SEL_A0  = 4'h4,
    SEL_A1  = 4'h5,
    SEL_FB  = 4'h6,
    SEL_SB  = 4'h7,
    SEL_VTB = 4'h8,
    SEL_PC  = 4'h9,
    SEL_USP = 4'hA,
    SEL_ISP = 4'hB,
    SEL_FLG = 4'hC,
    SEL_SP  = 4'hD
  } reg_sel_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } acc_size_t;

endpackage

// file: src/cpu_register_file_flags.sv
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

module cpu_register_file_flags
  import cpu_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                reset_i,
  // Core register write port
  input  wire logic                wr_en_i,
  input  wire reg_sel_t            wr_sel_i,
  input  wire acc_size_t           wr_size_i,
  input  wire logic                wr_hi_i,
  input  wire logic [LONG_W-1:0]   wr_data_i,
  // Core register read port
  input  wire reg_sel_t            rd_sel_i,
  input  wire acc_size_t           rd_size_i,
  input  wire logic                rd_hi_i,
  output logic [LONG_W-1:0]        rd_data_o,
  // Arithmetic flag results
  input  wire logic [AF_N-1:0]     alu_flag_we_i,
  input  wire logic [AF_N-1:0]     alu_flag_i,
  // Interrupt events
  input  wire logic                irq_req_i,
  input  wire logic                irq_maskable_i,
  input  wire logic [IPL_W-1:0]    irq_level_i,
  input  wire logic                irq_ack_i,
  input  wire logic                swi_exec_i,
  input  wire logic [SWI_W-1:0]    swi_num_i,
  output logic                     irq_accept_o,
  // Architectural state views
  output logic [FLAG_W-1:0]        flag_word_o,
  output logic [ADR20_W-1:0]       pc_o,
  output logic [ADR20_W-1:0]       vector_table_base_o,
  output logic [WORD_W-1:0]        static_base_ptr_o,
  output logic [WORD_W-1:0]        sp_o,
  // Avalon-MM slave
  input  wire logic [BUS_AW-1:0]   avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [BUS_DW-1:0]   avs_writedata_i,
  input  wire logic [BUS_BE_W-1:0] avs_byteenable_i,
  output logic [BUS_DW-1:0]        avs_readdata_o,
  output logic                     avs_waitrequest_o
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [WORD_W-1:0]  bank_ff [BANK_N][BANK_REGS];
  logic [WORD_W-1:0]  sb_ff;
  logic [ADR20_W-1:0] vtb_ff;
  logic [ADR20_W-1:0] pc_ff;
  logic [WORD_W-1:0]  usp_ff;
  logic [WORD_W-1:0]  isp_ff;
  logic [FLAG_W-1:0]  flag_ff;
  logic [WORD_W-1:0]  sp_view_ff;
  logic [LONG_W-1:0]  rd_data_ff;
  logic               accept_ff;
  logic               wait_ff;
  logic [BUS_DW-1:0]  readdata_ff;

  logic [FLAG_W-1:0]  nxt_flag;
  logic [WORD_W-1:0]  nxt_usp;
  logic [WORD_W-1:0]  nxt_isp;

  logic [BANK_REGS-1:0][1:0]        cw_be;
  logic [BANK_REGS-1:0][WORD_W-1:0] cw_dat;
  logic                bank_sel;
  logic                bus_wr;
  logic [IDX_W-1:0]    bus_idx;
  logic [BUS_DW-1:0]   bus_rd_val;
  logic [LONG_W-1:0]   core_rd_val;

  // Merge a word under a two-lane byte mask.
  function automatic logic [WORD_W-1:0] merge_w(
    input logic [WORD_W-1:0] old_v,
    input logic [WORD_W-1:0] new_v,
    input logic [1:0]        be
  );
    merge_w = old_v;
    if (be[0]) begin
      merge_w[BYTE_W-1:0] = new_v[BYTE_W-1:0];
    end
    if (be[1]) begin
      merge_w[WORD_W-1:BYTE_W] = new_v[WORD_W-1:BYTE_W];
    end
  endfunction

  // Merge a twenty-bit address under three byte lanes.
  function automatic logic [ADR20_W-1:0] merge_a(
    input logic [ADR20_W-1:0] old_v,
    input logic [BUS_DW-1:0]  new_v,
    input logic [2:0]         be
  );
    merge_a = old_v;
    merge_a[WORD_W-1:0] = merge_w(old_v[WORD_W-1:0],
                                  new_v[WORD_W-1:0], be[1:0]);
    if (be[2]) begin
      merge_a[ADR20_W-1:WORD_W] = new_v[ADR20_W-1:WORD_W];
    end
  endfunction

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // A write lands only on the edge where waitrequest is seen low.
  assign bus_wr   = avs_write_i && !wait_ff;
  assign bus_idx  = avs_address_i[BUS_AW-1:IDX_LSB];
  assign bank_sel = flag_ff[FLG_B];

  // ---------------------------------------------------------------
  // Core write decode for the banked entries
  // ---------------------------------------------------------------
  // Only the bank picked by the flag is touched by the core.
  always_comb begin
    cw_be  = '0;
    cw_dat = '0;
    if (wr_en_i) begin
      case (wr_size_i)
        SZ_BYTE: begin
          if (wr_sel_i == SEL_D0 || wr_sel_i == SEL_D1) begin
            cw_be[wr_sel_i[2:0]]  = wr_hi_i ? 2'h2 : 2'h1;
            cw_dat[wr_sel_i[2:0]] = {2{wr_data_i[BYTE_W-1:0]}};
          end
        end
        SZ_WORD: begin
          if (wr_sel_i <= SEL_FB) begin
            cw_be[wr_sel_i[2:0]]  = 2'h3;
            cw_dat[wr_sel_i[2:0]] = wr_data_i[WORD_W-1:0];
          end
        end
        SZ_LONG: begin
          case (wr_sel_i)
            SEL_D0: begin
              cw_be[E_D0]  = 2'h3;
              cw_be[E_D2]  = 2'h3;
              cw_dat[E_D0] = wr_data_i[WORD_W-1:0];
              cw_dat[E_D2] = wr_data_i[LONG_W-1:WORD_W];
            end
            SEL_D1: begin
              cw_be[E_D1]  = 2'h3;
              cw_be[E_D3]  = 2'h3;
              cw_dat[E_D1] = wr_data_i[WORD_W-1:0];
              cw_dat[E_D3] = wr_data_i[LONG_W-1:WORD_W];
            end
            SEL_A0: begin
              cw_be[E_A0]  = 2'h3;
              cw_be[E_A1]  = 2'h3;
              cw_dat[E_A0] = wr_data_i[WORD_W-1:0];
              cw_dat[E_A1] = wr_data_i[LONG_W-1:WORD_W];
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Banked registers
  // ---------------------------------------------------------------
  // One process per entry; the core outranks the bus on a clash,
  // so a debugger poke cannot corrupt an instruction result.
  for (genvar b = 0; b < BANK_N; b++) begin : g_bank
    for (genvar e = 0; e < BANK_REGS; e++) begin : g_ent
      localparam logic [IDX_W-1:0] MY_IDX =
        IDX_W'(b * BANK_STEP + e);
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          bank_ff[b][e] <= 16'h0000;
        end else if (cw_be[e] != 2'h0 && bank_sel == 1'(b)) begin
          bank_ff[b][e] <= merge_w(bank_ff[b][e], cw_dat[e],
                                   cw_be[e]);
        end else if (bus_wr && bus_idx == MY_IDX) begin
          bank_ff[b][e] <= merge_w(bank_ff[b][e],
                                   avs_writedata_i[WORD_W-1:0],
                                   avs_byteenable_i[1:0]);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Static base, vector table base and program counter
  // ---------------------------------------------------------------
  // Static base pointer storage.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sb_ff <= 16'h0000;
    end else if (wr_en_i && wr_sel_i == SEL_SB) begin
      sb_ff <= wr_data_i[WORD_W-1:0];
    end else if (bus_wr && bus_idx == IDX_SB) begin
      sb_ff <= merge_w(sb_ff, avs_writedata_i[WORD_W-1:0],
                       avs_byteenable_i[1:0]);
    end
  end

  // Vector table base; the core always writes all twenty bits.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      vtb_ff <= 20'h00000;
    end else if (wr_en_i && wr_sel_i == SEL_VTB) begin
      vtb_ff <= wr_data_i[ADR20_W-1:0];
    end else if (bus_wr && bus_idx == IDX_VTB) begin
      vtb_ff <= merge_a(vtb_ff, avs_writedata_i,
                        avs_byteenable_i[2:0]);
    end
  end

  // Program counter; the decoder supplies each next address.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pc_ff <= 20'h00000;
    end else if (wr_en_i && wr_sel_i == SEL_PC) begin
      pc_ff <= wr_data_i[ADR20_W-1:0];
    end else if (bus_wr && bus_idx == IDX_PC) begin
      pc_ff <= merge_a(pc_ff, avs_writedata_i,
                       avs_byteenable_i[2:0]);
    end
  end

  // ---------------------------------------------------------------
  // Stack pointers
  // ---------------------------------------------------------------
  // The generic stack selector follows the stack flag as it stands
  // before this edge, so a push in the acknowledge cycle still uses
  // the old pointer.
  always_comb begin
    nxt_usp = usp_ff;
    nxt_isp = isp_ff;
    if (bus_wr && bus_idx == IDX_USP) begin
      nxt_usp = merge_w(usp_ff, avs_writedata_i[WORD_W-1:0],
                        avs_byteenable_i[1:0]);
    end
    if (bus_wr && bus_idx == IDX_ISP) begin
      nxt_isp = merge_w(isp_ff, avs_writedata_i[WORD_W-1:0],
                        avs_byteenable_i[1:0]);
    end
    if (wr_en_i) begin
      if (wr_sel_i == SEL_USP ||
          (wr_sel_i == SEL_SP && flag_ff[FLG_U])) begin
        nxt_usp = wr_data_i[WORD_W-1:0];
      end
      if (wr_sel_i == SEL_ISP ||
          (wr_sel_i == SEL_SP && !flag_ff[FLG_U])) begin
        nxt_isp = wr_data_i[WORD_W-1:0];
      end
    end
  end

  // Stack pointer storage.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      usp_ff <= 16'h0000;
      isp_ff <= 16'h0000;
    end else begin
      usp_ff <= nxt_usp;
      isp_ff <= nxt_isp;
    end
  end

  // Active pointer view, built from next values so it never lags.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sp_view_ff <= 16'h0000;
    end else begin
      sp_view_ff <= nxt_flag[FLG_U] ? nxt_usp : nxt_isp;
    end
  end

  // ---------------------------------------------------------------
  // Flag word
  // ---------------------------------------------------------------
  // Priority from low to high: bus, instruction write, ALU result,
  // interrupt entry. The reserved bit is not stored at all.
  always_comb begin
    nxt_flag = flag_ff;
    if (bus_wr && bus_idx == IDX_FLG) begin
      if (avs_byteenable_i[0]) begin
        nxt_flag[BYTE_W-1:0] = avs_writedata_i[BYTE_W-1:0];
      end
      if (avs_byteenable_i[1]) begin
        nxt_flag[FLAG_W-1:FLG_IPL] =
          avs_writedata_i[FLAG_W-1:FLG_IPL];
      end
    end
    if (wr_en_i && wr_sel_i == SEL_FLG) begin
      nxt_flag = wr_data_i[FLAG_W-1:0];
    end
    if (alu_flag_we_i[AF_C]) begin
      nxt_flag[FLG_C] = alu_flag_i[AF_C];
    end
    if (alu_flag_we_i[AF_Z]) begin
      nxt_flag[FLG_Z] = alu_flag_i[AF_Z];
    end
    if (alu_flag_we_i[AF_S]) begin
      nxt_flag[FLG_S] = alu_flag_i[AF_S];
    end
    if (alu_flag_we_i[AF_O]) begin
      nxt_flag[FLG_O] = alu_flag_i[AF_O];
    end
    // Software interrupt entry masks and may switch stacks.
    if (swi_exec_i) begin
      nxt_flag[FLG_I] = 1'b0;
      if (swi_num_i <= SWI_CLR_MAX) begin
        nxt_flag[FLG_U] = 1'b0;
      end
    end
    // Hardware acknowledge wins over everything else.
    if (irq_ack_i) begin
      nxt_flag[FLG_I] = 1'b0;
      nxt_flag[FLG_U] = 1'b0;
    end
  end

  // Flag storage.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      flag_ff <= FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt acceptance
  // ---------------------------------------------------------------
  // Non-maskable requests skip both the enable and the level test.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      accept_ff <= 1'b0;
    end else begin
      accept_ff <= irq_req_i &&
                   (!irq_maskable_i ||
                    (flag_ff[FLG_I] &&
                     irq_level_i >
                     flag_ff[FLAG_W-1:FLG_IPL]));
    end
  end

  // ---------------------------------------------------------------
  // Core read port
  // ---------------------------------------------------------------
  // Banked reads follow the current bank; results appear one edge
  // after the select.
  always_comb begin
    core_rd_val = '0;
    case (rd_size_i)
      SZ_BYTE: begin
        if (rd_sel_i == SEL_D0 || rd_sel_i == SEL_D1) begin
          core_rd_val[BYTE_W-1:0] = rd_hi_i ?
            bank_ff[bank_sel][rd_sel_i[2:0]][WORD_W-1:BYTE_W] :
            bank_ff[bank_sel][rd_sel_i[2:0]][BYTE_W-1:0];
        end
      end
      SZ_WORD: begin
        case (rd_sel_i)
          SEL_SB:  core_rd_val[WORD_W-1:0] = sb_ff;
          SEL_VTB: core_rd_val[ADR20_W-1:0] = vtb_ff;
          SEL_PC:  core_rd_val[ADR20_W-1:0] = pc_ff;
          SEL_USP: core_rd_val[WORD_W-1:0] = usp_ff;
          SEL_ISP: core_rd_val[WORD_W-1:0] = isp_ff;
          SEL_SP:  core_rd_val[WORD_W-1:0] =
                     flag_ff[FLG_U] ? usp_ff : isp_ff;
          SEL_FLG: core_rd_val[FLAG_W-1:0] = flag_ff;
          default: core_rd_val[WORD_W-1:0] =
                     bank_ff[bank_sel][rd_sel_i[2:0]];
        endcase
      end
      SZ_LONG: begin
        case (rd_sel_i)
          SEL_D0: core_rd_val = {bank_ff[bank_sel][E_D2],
                                 bank_ff[bank_sel][E_D0]};
          SEL_D1: core_rd_val = {bank_ff[bank_sel][E_D3],
                                 bank_ff[bank_sel][E_D1]};
          SEL_A0: core_rd_val = {bank_ff[bank_sel][E_A1],
                                 bank_ff[bank_sel][E_A0]};
          SEL_VTB: core_rd_val[ADR20_W-1:0] = vtb_ff;
          SEL_PC:  core_rd_val[ADR20_W-1:0] = pc_ff;
          default: core_rd_val = '0;
        endcase
      end
      default: core_rd_val = '0;
    endcase
  end

  // Registered read result.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_data_ff <= 32'h00000000;
    end else begin
      rd_data_ff <= core_rd_val;
    end
  end

  // ---------------------------------------------------------------
  // Bus read mux and handshake
  // ---------------------------------------------------------------
  // Unmapped indices, including the spare slot of each bank, read 0.
  always_comb begin
    bus_rd_val = '0;
    case (bus_idx)
      IDX_SB:  bus_rd_val[WORD_W-1:0] = sb_ff;
      IDX_VTB: bus_rd_val[ADR20_W-1:0] = vtb_ff;
      IDX_PC:  bus_rd_val[ADR20_W-1:0] = pc_ff;
      IDX_USP: bus_rd_val[WORD_W-1:0] = usp_ff;
      IDX_ISP: bus_rd_val[WORD_W-1:0] = isp_ff;
      IDX_FLG: bus_rd_val[FLAG_W-1:0] = flag_ff;
      default: begin
        if (!bus_idx[IDX_W-1] && bus_idx[2:0] < BANK_REGS) begin
          bus_rd_val[WORD_W-1:0] =
            bank_ff[bus_idx[IDX_W-2]][bus_idx[2:0]];
        end
      end
    endcase
  end

  // Every access takes exactly one wait state.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !((avs_read_i || avs_write_i) && wait_ff);
    end
  end

  // Read data is sampled in the wait cycle and held afterwards.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      readdata_ff <= 32'h00000000;
    end else if (avs_read_i && wait_ff) begin
      readdata_ff <= bus_rd_val;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rd_data_o           = rd_data_ff;
  assign irq_accept_o        = accept_ff;
  assign flag_word_o         = flag_ff;
  assign pc_o                = pc_ff;
  assign vector_table_base_o = vtb_ff;
  assign static_base_ptr_o   = sb_ff;
  assign sp_o                = sp_view_ff;
  assign avs_readdata_o      = readdata_ff;
  assign avs_waitrequest_o   = wait_ff;

endmodule

// file: tb/alu_model.sv
`timescale 1ns/1ps
module alu_model
  import cpu_regs_pkg::*;
(
  // Operands
  input  wire logic [WORD_W-1:0] op_a_i,
  input  wire logic [WORD_W-1:0] op_b_i,
  // Flag lanes C Z S O
  output logic      [AF_N-1:0]   flag_o
);
  logic [WORD_W:0] sum;
  // Plain add; overflow only when like signs give an unlike result.
  always_comb begin
    sum = op_a_i + op_b_i;
    flag_o[AF_C] = sum[WORD_W];
    flag_o[AF_Z] = sum[WORD_W-1:0] == 16'h0000;
    flag_o[AF_S] = sum[WORD_W-1];
    flag_o[AF_O] = op_a_i[15] == op_b_i[15] &&
                   sum[15] != op_a_i[15];
  end
endmodule

// file: tb/cpu_regs_asserts.sv
`timescale 1ns/1ps
module cpu_regs_asserts
  import cpu_regs_pkg::*;
(
  // Clock, reset, core inputs and bus strobes
  input wire logic               core_clk_i,
  input wire logic               reset_i,
  input wire logic               wr_en_i,
  input wire reg_sel_t           wr_sel_i,
  input wire acc_size_t          wr_size_i,
  input wire logic [LONG_W-1:0]  wr_data_i,
  input wire logic [AF_N-1:0]    alu_flag_we_i,
  input wire logic [AF_N-1:0]    alu_flag_i,
  input wire logic               irq_req_i,
  input wire logic               irq_maskable_i,
  input wire logic [IPL_W-1:0]   irq_level_i,
  input wire logic               irq_ack_i,
  input wire logic               swi_exec_i,
  input wire logic [SWI_W-1:0]   swi_num_i,
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  // Design outputs
  input wire logic               irq_accept_o,
  input wire logic [FLAG_W-1:0]  flag_word_o,
  input wire logic [ADR20_W-1:0] pc_o,
  input wire logic [ADR20_W-1:0] vector_table_base_o,
  input wire logic [WORD_W-1:0]  static_base_ptr_o,
  input wire logic               avs_waitrequest_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  logic want_ff;
  // Expected acceptance, one edge behind, as the design registers it.
  always_ff @(posedge core_clk_i) begin
    want_ff <= irq_req_i && (!irq_maskable_i || (flag_word_o[FLG_I]
               && irq_level_i > flag_word_o[FLAG_W-1:FLG_IPL]));
  end
  // A bus request waits exactly one cycle, then the slave goes busy again.
  sequence bus_req_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence bus_ans_s;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  bus_wait_a: assert property (bus_req_s |=> bus_ans_s)
    else $error("bus answer not after one wait cycle");
  ack_clear_a: assert property (irq_ack_i |=>
    !flag_word_o[FLG_I] && !flag_word_o[FLG_U])
    else $error("acknowledge left I or U set");
  swi_stack_a: assert property (
    swi_exec_i && swi_num_i <= SWI_CLR_MAX |=> !flag_word_o[FLG_U])
    else $error("low software vector left U set");
  irq_gate_a: assert property (
    !$past(reset_i) |-> irq_accept_o == want_ff)
    else $error("interrupt acceptance wrong");
  alu_lanes_a: assert property (
    alu_flag_we_i == 4'hF |=> {flag_word_o[FLG_O], flag_word_o[FLG_S],
    flag_word_o[FLG_Z], flag_word_o[FLG_C]} == $past(alu_flag_i))
    else $error("arithmetic flags not taken");
  sb_load_a: assert property (
    wr_en_i && wr_sel_i == SEL_SB && wr_size_i == SZ_WORD
    |=> static_base_ptr_o == WORD_W'($past(wr_data_i)))
    else $error("static base not loaded");
  pc_load_a: assert property (
    wr_en_i && wr_sel_i == SEL_PC && wr_size_i != SZ_BYTE
    |=> pc_o == ADR20_W'($past(wr_data_i)))
    else $error("program counter not loaded");
  vtb_load_a: assert property (
    wr_en_i && wr_sel_i == SEL_VTB && wr_size_i != SZ_BYTE
    |=> vector_table_base_o == ADR20_W'($past(wr_data_i)))
    else $error("vector table base not loaded");
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import cpu_regs_pkg::*;
;
  logic                core_clk_i, reset_i, wr_en_i, wr_hi_i, rd_hi_i;
  logic                irq_req_i, irq_maskable_i, irq_ack_i, swi_exec_i;
  logic                avs_read_i, avs_write_i, avs_waitrequest_o;
  logic                irq_accept_o;
  reg_sel_t            wr_sel_i, rd_sel_i;
  acc_size_t           wr_size_i, rd_size_i;
  logic [LONG_W-1:0]   wr_data_i, rd_data_o, avs_writedata_i, avs_readdata_o;
  logic [AF_N-1:0]     alu_flag_we_i, alu_flag_i;
  logic [IPL_W-1:0]    irq_level_i;
  logic [SWI_W-1:0]    swi_num_i;
  logic [FLAG_W-1:0]   flag_word_o;
  logic [ADR20_W-1:0]  pc_o, vector_table_base_o;
  logic [WORD_W-1:0]   static_base_ptr_o, sp_o, op_a, op_b;
  logic [BUS_AW-1:0]   avs_address_i;
  logic [BUS_BE_W-1:0] avs_byteenable_i;
  int                  err_count, n_tests, cyc;

  alu_model alu_u (.op_a_i(op_a), .op_b_i(op_b), .flag_o(alu_flag_i));
  cpu_register_file_flags dut (.*);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task final_report;
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Bus cycle: hold the request until waitrequest is seen low at an edge.
  task automatic bus(input logic w, input logic [4:0] i,
                     input logic [31:0] d, input logic [31:0] e);
    @(posedge core_clk_i);
    avs_address_i <= {i, 2'b00};
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (!w) chk(avs_readdata_o, e);
  endtask

  // Core write: a one-cycle strobe, then let the edge's update settle.
  task automatic cw(input reg_sel_t s, input acc_size_t z, input logic h,
                    input logic [31:0] d);
    @(posedge core_clk_i);
    wr_en_i <= 1'b1;
    wr_sel_i <= s;
    wr_size_i <= z;
    wr_hi_i <= h;
    wr_data_i <= d;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
    #1;
  endtask

  // Core read: the read port is registered, so look one edge later.
  task automatic cr(input reg_sel_t s, input acc_size_t z, input logic h,
                    input logic [31:0] e);
    @(posedge core_clk_i);
    rd_sel_i <= s;
    rd_size_i <= z;
    rd_hi_i <= h;
    @(posedge core_clk_i);
    #1 chk(rd_data_o, e);
  endtask

  // Interrupt events and arithmetic results, each a one-cycle pulse.
  task automatic ev(input logic a, input logic s, input logic [5:0] n,
                    input logic [15:0] x, input logic [10:0] e);
    @(posedge core_clk_i);
    irq_ack_i <= a;
    swi_exec_i <= s;
    swi_num_i <= n;
    op_a <= x;
    op_b <= 16'h0001;
    alu_flag_we_i <= {4{!a && !s}};
    @(posedge core_clk_i);
    {irq_ack_i, swi_exec_i, alu_flag_we_i} <= 6'h00;
    #1 chk(flag_word_o, e);
  endtask

  task automatic irq(input logic m, input logic [2:0] l, input logic e);
    @(posedge core_clk_i);
    irq_req_i <= 1'b1;
    irq_maskable_i <= m;
    irq_level_i <= l;
    @(posedge core_clk_i);
    #1 chk(irq_accept_o, e);
  endtask

  // Clock of 10 ns, and a hang limit far above the fewer than one hundred cycles used.
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end

  // Main sequence.
  initial begin
    {wr_en_i, wr_hi_i, rd_hi_i, irq_req_i, irq_maskable_i, irq_ack_i} = '0;
    {swi_exec_i, avs_read_i, avs_write_i, irq_level_i, swi_num_i} = '0;
    {wr_data_i, avs_writedata_i, avs_address_i, alu_flag_we_i} = '0;
    {op_a, op_b} = '0;
    wr_sel_i = SEL_D0;
    rd_sel_i = SEL_D0;
    wr_size_i = SZ_WORD;
    rd_size_i = SZ_WORD;
    avs_byteenable_i = 4'hF;
    reset_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    bus(1'b0, IDX_FLG, 32'h0, 32'h0);
    bus(1'b1, 5'h00, 32'h1234, 32'h0);
    cw(SEL_FLG, SZ_WORD, 1'b0, 32'h010);
    cw(SEL_D0, SZ_WORD, 1'b0, 32'hBEEF);
    cw(SEL_FLG, SZ_WORD, 1'b0, 32'h000);
    bus(1'b0, 5'h08, 32'h0, 32'hBEEF);
    bus(1'b0, 5'h00, 32'h0, 32'h1234);
    cw(SEL_D0, SZ_BYTE, 1'b1, 32'hAB);
    bus(1'b0, 5'h00, 32'h0, 32'hAB34);
    cr(SEL_D0, SZ_BYTE, 1'b1, 32'hAB);
    cw(SEL_D0, SZ_LONG, 1'b0, 32'h89ABCDEF);
    bus(1'b0, 5'h02, 32'h0, 32'h89AB);
    cr(SEL_D0, SZ_LONG, 1'b0, 32'h89ABCDEF);
    cw(SEL_A0, SZ_LONG, 1'b0, 32'h11223344);
    cr(SEL_A0, SZ_LONG, 1'b0, 32'h11223344);
    bus(1'b1, 5'h06, 32'hFFFF5A5A, 32'h0);
    bus(1'b0, 5'h06, 32'h0, 32'h5A5A);
    bus(1'b0, 5'h07, 32'h0, 32'h0);
    cw(SEL_SB, SZ_WORD, 1'b0, 32'hFFFFC3C3);
    chk(static_base_ptr_o, 32'hC3C3);
    cw(SEL_VTB, SZ_WORD, 1'b0, 32'hFFFABCDE);
    chk(vector_table_base_o, 32'hABCDE);
    cr(SEL_VTB, SZ_WORD, 1'b0, 32'hABCDE);
    cw(SEL_PC, SZ_LONG, 1'b0, 32'hFFF12345);
    chk(pc_o, 32'h12345);
    cw(SEL_USP, SZ_WORD, 1'b0, 32'h1111);
    cw(SEL_ISP, SZ_WORD, 1'b0, 32'h2222);
    chk(sp_o, 32'h2222);
    cw(SEL_FLG, SZ_WORD, 1'b0, 32'h0C0);
    chk(sp_o, 32'h1111);
    cw(SEL_SP, SZ_WORD, 1'b0, 32'h3333);
    chk(sp_o, 32'h3333);
    cr(SEL_USP, SZ_WORD, 1'b0, 32'h3333);
    cr(SEL_SP, SZ_WORD, 1'b0, 32'h3333);
    ev(1'b0, 1'b1, 6'h20, 16'h0000, 11'h080);
    ev(1'b0, 1'b1, 6'h1F, 16'h0000, 11'h000);
    cw(SEL_FLG, SZ_WORD, 1'b0, 32'h0C0);
    ev(1'b1, 1'b0, 6'h00, 16'h0000, 11'h000);
    ev(1'b0, 1'b0, 6'h00, 16'h7FFF, 11'h028);
    ev(1'b0, 1'b0, 6'h00, 16'hFFFF, 11'h005);
    cw(SEL_FLG, SZ_WORD, 1'b0, 32'h340);
    irq(1'b1, 3'h3, 1'b0);
    irq(1'b1, 3'h4, 1'b1);
    cw(SEL_FLG, SZ_WORD, 1'b0, 32'h300);
    irq(1'b1, 3'h7, 1'b0);
    irq(1'b0, 3'h0, 1'b1);
    final_report();
  end
endmodule

bind cpu_register_file_flags cpu_regs_asserts chk_u (.*);
